// ### core/clt_pkg.sv
/*
  Package for the charger limit and thermal configuration register bank:
  register offsets, field positions, reset values and decoded setting types.
  Assumes a byte-wide register access port from the serial interface logic.
*/
package clt_pkg;

  // Register offsets on the serial register port
  localparam logic [7:0] CLT_OFS_INPUT_LIMIT = 8'h07;
  localparam logic [7:0] CLT_OFS_TOPOFF = 8'h08;
  localparam logic [7:0] CLT_OFS_THERMAL = 8'h09;
  localparam logic [7:0] CLT_OFS_PROTECT = 8'h0A;

  // Input-limit register fields
  localparam int CLT_POS_RESTART = 6;
  localparam int CLT_POS_ILIM = 0;
  localparam logic [5:0] CLT_RST_ILIM = 6'h14;
  localparam logic CLT_RST_RESTART = 1'b0;
  localparam logic [5:0] CLT_ILIM_LOW_LAST = 6'h09;
  localparam logic [5:0] CLT_ILIM_MAX_CODE = 6'h3C;
  localparam logic [5:0] CLT_ILIM_OFF_CODE = 6'h3F;
  localparam logic [10:0] CLT_ILIM_LOW_MA = 11'd100;
  localparam logic [10:0] CLT_ILIM_BASE_MA = 11'd250;
  localparam logic [10:0] CLT_ILIM_STEP_MA = 11'd25;
  localparam logic [10:0] CLT_ILIM_MAX_MA = 11'd1500;
  localparam int CLT_TRIP_PCT = 95;

  // Topoff register fields
  localparam int CLT_POS_TOFF_TIMER = 5;
  localparam int CLT_POS_TEST_SCALE = 4;
  localparam int CLT_POS_TOFF_THR = 2;
  localparam int CLT_POS_TERM_V = 0;
  localparam logic [2:0] CLT_RST_TOFF_TIMER = 3'h3;
  localparam logic CLT_RST_TEST_SCALE = 1'b0;
  localparam logic [1:0] CLT_RST_TOFF_THR = 2'h0;
  localparam logic [1:0] CLT_RST_TERM_V = 2'h0;
  localparam logic [6:0] CLT_TOFF_STEP_MIN = 7'd10;
  localparam logic [7:0] CLT_TOFF_THR_STEP_MA = 8'd50;

  // Thermal register fields
  localparam int CLT_POS_DIE_TEMP = 6;
  localparam int CLT_POS_THM_OFF = 3;
  localparam int CLT_POS_SAFETY = 0;
  localparam logic [1:0] CLT_RST_DIE_TEMP = 2'h0;
  localparam logic CLT_RST_SAFETY = 1'b0;

  // Protection key field
  localparam int CLT_POS_KEY = 2;
  localparam logic [1:0] CLT_KEY_UNLOCK = 2'h3;
  localparam logic [1:0] CLT_RST_KEY = 2'h0;

  // Termination voltage selections, in code order
  typedef enum logic [1:0] {
    CLT_V_4P20 = 2'b00,
    CLT_V_4P10 = 2'b01,
    CLT_V_4P35 = 2'b10,
    CLT_V_4P15 = 2'b11
  } clt_term_v_e;

  // Die-temperature setpoints, in code order
  typedef enum logic [1:0] {
    CLT_T_105C = 2'b00,
    CLT_T_90C = 2'b01,
    CLT_T_120C = 2'b10,
    CLT_T_OFF = 2'b11
  } clt_die_temp_e;

  // Stored configuration fields
  typedef struct packed {
    logic restart_threshold_sel;
    logic [5:0] input_current_limit_code;
    logic [2:0] finish_timer_code;
    logic high_current_test_scale;
    logic [1:0] finish_current_threshold;
    logic [1:0] termination_voltage_code;
    logic [1:0] die_temp_setpoint;
    logic thermistor_monitor_off;
    logic safety_region_sel;
    logic [1:0] write_protect_key;
  } clt_cfg_s;

  // Decoded settings for the analog control loops
  typedef struct packed {
    logic restart_100mv;
    logic limit_disable;
    logic [10:0] limit_target_ma;
    logic [10:0] limit_trip_ma;
    logic [6:0] topoff_minutes;
    logic [7:0] topoff_current_ma;
    logic test_scale_2p8a;
    clt_term_v_e term_voltage;
    clt_die_temp_e die_temp;
    logic thermistor_monitor_off;
    logic safety_region2;
  } clt_ctl_s;

endpackage : clt_pkg

// ### core/clt_decode.sv
/*
  Settings decoder: turns the stored register fields into the current,
  time, voltage and temperature selections the charger loops consume.
  Purely combinational; the top registers its outputs.
*/
`timescale 1ns/1ps
module clt_decode (
  input wire clt_pkg::clt_cfg_s i_cfg,
  output clt_pkg::clt_ctl_s o_ctl
);
  import clt_pkg::*;

  // Target current in mA for an input-limit code
  function automatic logic [10:0] clt_limit_ma(input logic [5:0] code);
    logic [10:0] ma;
    ma = CLT_ILIM_LOW_MA;
    if (code > CLT_ILIM_MAX_CODE) begin
      ma = CLT_ILIM_MAX_MA;
    end else if (code > CLT_ILIM_LOW_LAST) begin
      ma = CLT_ILIM_BASE_MA + CLT_ILIM_STEP_MA *
           11'(code - CLT_ILIM_LOW_LAST - 6'h01);
    end
    return ma;
  endfunction : clt_limit_ma

  logic [10:0] target_ma;
  logic [17:0] trip_prod;

  // Limit target and the 95 percent trip point, truncated to whole mA
  always_comb begin
    target_ma = clt_limit_ma(i_cfg.input_current_limit_code);
    trip_prod = 18'(target_ma) * 18'(CLT_TRIP_PCT);
  end

  // Field decoding
  always_comb begin
    o_ctl.restart_100mv = i_cfg.restart_threshold_sel;
    o_ctl.limit_disable =
      (i_cfg.input_current_limit_code == CLT_ILIM_OFF_CODE);
    o_ctl.limit_target_ma = target_ma;
    o_ctl.limit_trip_ma = 11'(trip_prod / 18'd100);
    o_ctl.topoff_minutes =
      7'(i_cfg.finish_timer_code) * CLT_TOFF_STEP_MIN;
    o_ctl.topoff_current_ma = CLT_TOFF_THR_STEP_MA *
      (8'(i_cfg.finish_current_threshold) + 8'h01);
    o_ctl.test_scale_2p8a = i_cfg.high_current_test_scale;
    o_ctl.term_voltage =
      clt_term_v_e'(i_cfg.termination_voltage_code);
    o_ctl.die_temp = clt_die_temp_e'(i_cfg.die_temp_setpoint);
    o_ctl.thermistor_monitor_off = i_cfg.thermistor_monitor_off;
    o_ctl.safety_region2 = i_cfg.safety_region_sel;
  end

endmodule : clt_decode

// ### core/clt_regs.sv
/*
  Write-protected charger configuration register bank: input limit and
  restart threshold, topoff and termination voltage, thermal settings,
  and the protection key register that gates them.
  Assumes a serial interface block on i_mclk that presents one byte
  access per single-cycle strobe; supply-status pins are asynchronous.
*/
`timescale 1ns/1ps

// Function
// - Restart threshold bit: 0 means -150mV, 1 means -100mV.
// - Six-bit limit code: 100mA low codes, 250..1500mA in 25mA, all-ones off.
// - Applied trip threshold is 95 percent of the target limit.
// - Limit defaults to the 500mA code, restart bit defaults to 0.
// - Topoff time is code times ten minutes, default code 3.
// - Test-scale bit lifts fast-charge maximum to 2.8A, default off.
// - Topoff starts at 50, 100, 150 or 200mA, default 50mA.
// - Termination voltage 4.2, 4.10, 4.35 or 4.15V, default 4.2V.
// - Die setpoint 105, 90, 120C or loop off, default 105C.
// - Thermistor bit: 0 monitors continuously, 1 does not; variant default.
// - Safety region select bit, 0 region 1, 1 region 2, default 0.
// - Registers return to defaults on standby loss or power-good rise.
// - Writes other than to the key land only while key holds 11; other key values relock.
module clt_regs #(
  parameter logic THM_OFF_DEFAULT = 1'b1
) (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_wr_stb,
  input wire logic i_rd_stb,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  output logic o_rvalid,
  input wire logic i_standby_supply_ok,
  input wire logic i_safe_output_power_good,
  output clt_pkg::clt_ctl_s o_ctl,
  output logic o_unlocked
);
  import clt_pkg::*;

  // Field defaults packed into one constant
  function automatic clt_cfg_s clt_defaults(input logic thm_off);
    clt_cfg_s d;
    d.restart_threshold_sel = CLT_RST_RESTART;
    d.input_current_limit_code = CLT_RST_ILIM;
    d.finish_timer_code = CLT_RST_TOFF_TIMER;
    d.high_current_test_scale = CLT_RST_TEST_SCALE;
    d.finish_current_threshold = CLT_RST_TOFF_THR;
    d.termination_voltage_code = CLT_RST_TERM_V;
    d.die_temp_setpoint = CLT_RST_DIE_TEMP;
    d.thermistor_monitor_off = thm_off;
    d.safety_region_sel = CLT_RST_SAFETY;
    d.write_protect_key = CLT_RST_KEY;
    return d;
  endfunction : clt_defaults

  localparam clt_cfg_s CFG_DEFAULT = clt_defaults(THM_OFF_DEFAULT);

  // Three-stage synchronisers for the supply status pins
  logic [2:0] stby_sync_r;
  logic [2:0] stby_sync_nxt;
  logic [2:0] pok_sync_r;
  logic [2:0] pok_sync_nxt;
  logic stby_ok_r;
  logic stby_ok_nxt;
  logic pok_r;
  logic pok_nxt;
  logic default_req;

  // Shift pins in; a level counts once stages two and three agree
  always_comb begin
    stby_sync_nxt = {stby_sync_r[1:0], i_standby_supply_ok};
    pok_sync_nxt = {pok_sync_r[1:0], i_safe_output_power_good};
    stby_ok_nxt = stby_ok_r;
    pok_nxt = pok_r;
    if (stby_sync_r[1] == stby_sync_r[2]) begin
      stby_ok_nxt = stby_sync_r[2];
    end
    if (pok_sync_r[1] == pok_sync_r[2]) begin
      pok_nxt = pok_sync_r[2];
    end
  end

  // Supply state resets as "invalid", so the bank starts at defaults
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      stby_sync_r <= 3'h0;
      pok_sync_r <= 3'h0;
      stby_ok_r <= 1'b0;
      pok_r <= 1'b0;
    end else begin
      stby_sync_r <= stby_sync_nxt;
      pok_sync_r <= pok_sync_nxt;
      stby_ok_r <= stby_ok_nxt;
      pok_r <= pok_nxt;
    end
  end

  // Defaults while standby is invalid or on the power-good rising edge
  assign default_req = !stby_ok_r || (pok_nxt && !pok_r);

  // Configuration storage
  clt_cfg_s cfg_r;
  clt_cfg_s cfg_nxt;
  logic unlocked;

  assign unlocked = (cfg_r.write_protect_key == CLT_KEY_UNLOCK);

  // Write decode; the key register itself is never locked
  always_comb begin
    cfg_nxt = cfg_r;
    if (default_req) begin
      cfg_nxt = CFG_DEFAULT;
    end else if (i_wr_stb) begin
      case (i_addr)
        CLT_OFS_INPUT_LIMIT: begin
          if (unlocked) begin
            cfg_nxt.restart_threshold_sel = i_wdata[CLT_POS_RESTART];
            cfg_nxt.input_current_limit_code =
              i_wdata[CLT_POS_ILIM +: 6];
          end
        end
        CLT_OFS_TOPOFF: begin
          if (unlocked) begin
            cfg_nxt.finish_timer_code = i_wdata[CLT_POS_TOFF_TIMER +: 3];
            cfg_nxt.high_current_test_scale = i_wdata[CLT_POS_TEST_SCALE];
            cfg_nxt.finish_current_threshold =
              i_wdata[CLT_POS_TOFF_THR +: 2];
            cfg_nxt.termination_voltage_code =
              i_wdata[CLT_POS_TERM_V +: 2];
          end
        end
        CLT_OFS_THERMAL: begin
          if (unlocked) begin
            cfg_nxt.die_temp_setpoint = i_wdata[CLT_POS_DIE_TEMP +: 2];
            cfg_nxt.thermistor_monitor_off = i_wdata[CLT_POS_THM_OFF];
            cfg_nxt.safety_region_sel = i_wdata[CLT_POS_SAFETY];
          end
        end
        CLT_OFS_PROTECT: begin
          cfg_nxt.write_protect_key = i_wdata[CLT_POS_KEY +: 2];
        end
        default: begin
          cfg_nxt = cfg_r; // Unmapped writes are dropped
        end
      endcase
    end
  end

  // Asynchronous reset loads constants only
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      cfg_r <= CFG_DEFAULT;
    end else begin
      cfg_r <= cfg_nxt;
    end
  end

  // Read mux; reserved positions and unmapped offsets read zero
  logic [7:0] rdata_nxt;
  logic [7:0] rdata_r;
  logic rvalid_r;

  always_comb begin
    rdata_nxt = 8'h00;
    case (i_addr)
      CLT_OFS_INPUT_LIMIT: begin
        rdata_nxt[CLT_POS_RESTART] = cfg_r.restart_threshold_sel;
        rdata_nxt[CLT_POS_ILIM +: 6] = cfg_r.input_current_limit_code;
      end
      CLT_OFS_TOPOFF: begin
        rdata_nxt[CLT_POS_TOFF_TIMER +: 3] = cfg_r.finish_timer_code;
        rdata_nxt[CLT_POS_TEST_SCALE] = cfg_r.high_current_test_scale;
        rdata_nxt[CLT_POS_TOFF_THR +: 2] = cfg_r.finish_current_threshold;
        rdata_nxt[CLT_POS_TERM_V +: 2] = cfg_r.termination_voltage_code;
      end
      CLT_OFS_THERMAL: begin
        rdata_nxt[CLT_POS_DIE_TEMP +: 2] = cfg_r.die_temp_setpoint;
        rdata_nxt[CLT_POS_THM_OFF] = cfg_r.thermistor_monitor_off;
        rdata_nxt[CLT_POS_SAFETY] = cfg_r.safety_region_sel;
      end
      CLT_OFS_PROTECT: begin
        rdata_nxt[CLT_POS_KEY +: 2] = cfg_r.write_protect_key;
      end
      default: begin
        rdata_nxt = 8'h00;
      end
    endcase
  end

  // Read data holds until the next read strobe
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      rdata_r <= 8'h00;
      rvalid_r <= 1'b0;
    end else begin
      rdata_r <= i_rd_stb ? rdata_nxt : rdata_r;
      rvalid_r <= i_rd_stb;
    end
  end

  // Decoded settings, registered so every output leaves a flip-flop
  clt_ctl_s ctl_comb;
  clt_ctl_s ctl_r;
  logic unlocked_r;

  clt_decode u_decode (
    .i_cfg(cfg_r),
    .o_ctl(ctl_comb)
  );

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      ctl_r <= '0;
      unlocked_r <= 1'b0;
    end else begin
      ctl_r <= ctl_comb;
      unlocked_r <= unlocked;
    end
  end

  assign o_rdata = rdata_r;
  assign o_rvalid = rvalid_r;
  assign o_ctl = ctl_r;
  assign o_unlocked = unlocked_r;

endmodule : clt_regs

// ### tb/clt_regs_chk.sv
/*
  Checker for the charger config bank: read timing, key, decode ranges.
  Sees only the clt_regs ports; bound below.
*/
`timescale 1ns/1ps
module clt_regs_chk (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_wr_stb,
  input wire logic i_rd_stb,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] o_rdata,
  input wire logic o_rvalid,
  input wire logic i_standby_supply_ok,
  input wire logic i_safe_output_power_good,
  input wire clt_pkg::clt_ctl_s o_ctl,
  input wire logic o_unlocked
);
  import clt_pkg::*;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  // Bank back at the 500mA, 30min defaults
  sequence s_dflt;
    o_ctl.limit_target_ma == 11'd500 && o_ctl.topoff_minutes == 7'd30;
  endsequence
  a_read_answer: assert property (i_rd_stb |=> o_rvalid)
    else $error("no rvalid after read");
  a_key_relock: assert property (
    i_wr_stb && i_addr == CLT_OFS_PROTECT && i_wdata[3:2] != 2'h3
    |=> ##1 !o_unlocked) else $error("key write left bank open");
  // Lock flag lags the key by one cycle, so skip writes right after a key
  a_locked_hold: assert property (
    !o_unlocked && i_wr_stb && i_addr == CLT_OFS_INPUT_LIMIT &&
    !($past(i_wr_stb) && $past(i_addr) == CLT_OFS_PROTECT)
    |=> ##1 $stable(o_ctl)) else $error("locked write changed settings");
  a_trip_ratio: assert property (
    !o_ctl.limit_disable |-> o_ctl.limit_trip_ma ==
    11'((32'(o_ctl.limit_target_ma) * 95) / 100)) else $error("bad trip");
  a_limit_range: assert property (
    $past(i_nrst) && !o_ctl.limit_disable |-> o_ctl.limit_target_ma
    inside {11'd100, [11'd250:11'd1500]}) else $error("bad limit");
  a_thr_steps: assert property ($past(i_nrst) |->
    o_ctl.topoff_current_ma inside {8'd50, 8'd100, 8'd150, 8'd200})
    else $error("bad topoff current");
  a_stby_dflt: assert property (
    $fell(i_standby_supply_ok) |-> ##[1:8] s_dflt)
    else $error("no defaults after supply loss");
  a_pgood_dflt: assert property (
    $rose(i_safe_output_power_good) |-> ##[1:8] s_dflt)
    else $error("no defaults after power good");
  a_rsvd_zero: assert property (
    o_rvalid && $past(i_addr) == CLT_OFS_THERMAL
    |-> o_rdata[5:4] == 2'h0 && o_rdata[2:1] == 2'h0)
    else $error("reserved bits not zero");
endmodule : clt_regs_chk

bind clt_regs clt_regs_chk u_chk (
  .i_mclk(i_mclk), .i_nrst(i_nrst), .i_wr_stb(i_wr_stb),
  .i_rd_stb(i_rd_stb), .i_addr(i_addr), .i_wdata(i_wdata),
  .o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_ctl(o_ctl),
  .i_standby_supply_ok(i_standby_supply_ok), .o_unlocked(o_unlocked),
  .i_safe_output_power_good(i_safe_output_power_good)
);

// ### tb/clt_host.sv
/*
  Host model: single-byte transfers on the strobe register port.
  Assumes the bench clock; the read answer comes one cycle on.
*/
`timescale 1ns/1ps
module clt_host (
  input wire logic i_mclk,
  input wire logic [7:0] i_rdata,
  input wire logic i_rvalid,
  output logic o_wr_stb,
  output logic o_rd_stb,
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata
);
  import clt_pkg::*;
  // Idle port at time zero
  initial begin
    o_wr_stb = 1'b0;
    o_rd_stb = 1'b0;
    o_addr = 8'h00;
    o_wdata = 8'h00;
  end
  // Released bus shows inverted leftovers, never the old value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    #1;
    o_wr_stb = 1'b1;
    o_addr = a;
    o_wdata = d;
    @(posedge i_mclk);
    #1;
    o_wr_stb = 1'b0;
    o_addr = ~a;
    o_wdata = ~d;
  endtask : wr
  // Answer taken one cycle after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    output logic v);
    @(posedge i_mclk);
    #1;
    o_rd_stb = 1'b1;
    o_addr = a;
    @(posedge i_mclk);
    #1;
    o_rd_stb = 1'b0;
    o_addr = ~a;
    d = i_rdata;
    v = i_rvalid;
  endtask : rd
  // Key 11 opens the bank, any other value shuts it
  task automatic key(input logic [1:0] k);
    wr(CLT_OFS_PROTECT, {4'h0, k, 2'h0});
  endtask : key
endmodule : clt_host

// ### tb/testbench.sv
/*
  Bench for the charger config bank: host model on the register port,
  supply pins driven here. Assumes a 100 MHz clock.
*/
`timescale 1ns/1ps
module testbench;
  import clt_pkg::*;
  logic i_mclk, i_nrst, stby_ok, pgood, wr, rd, rvalid, unlocked;
  logic [7:0] addr, wdata, rdata;
  clt_ctl_s ctl;
  int n_mismatch = 0;
  int n_checks = 0;
  int cyc = 0;
  clt_regs u_dut (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_wr_stb(wr),
    .i_rd_stb(rd), .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata),
    .o_rvalid(rvalid), .i_standby_supply_ok(stby_ok), .o_ctl(ctl),
    .i_safe_output_power_good(pgood), .o_unlocked(unlocked));
  clt_host u_host (.i_mclk(i_mclk), .i_rdata(rdata), .i_rvalid(rvalid),
    .o_wr_stb(wr), .o_rd_stb(rd), .o_addr(addr), .o_wdata(wdata));
  task automatic final_report;
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s: expected %0h seen %0h", nm, e, g);
    end
  endtask : chk
  task automatic rdchk(logic [7:0] a, logic [7:0] e);
    logic [7:0] d;
    logic v;
    u_host.rd(a, d, v);
    chk("rvalid", 1, v);
    chk("rdata", e, d);
  endtask : rdchk
  task automatic t_defaults;
    rdchk(CLT_OFS_INPUT_LIMIT, 8'h14);
    rdchk(CLT_OFS_TOPOFF, 8'h60);
    rdchk(CLT_OFS_THERMAL, 8'h08);
    chk("target", 500, ctl.limit_target_ma);
    chk("scale", 0, ctl.test_scale_2p8a);
  endtask : t_defaults
  task automatic t_locked;
    u_host.wr(CLT_OFS_INPUT_LIMIT, 8'h3F);
    rdchk(CLT_OFS_INPUT_LIMIT, 8'h14);
    rdchk(8'h3F, 8'h00);
  endtask : t_locked
  // Limit code boundaries, one undefined code and the off code
  task automatic t_ilim;
    logic [5:0] c [6] = '{6'h09, 6'h0A, 6'h13, 6'h3C, 6'h3D, 6'h3F};
    int ma [6] = '{100, 250, 475, 1500, 1500, 0};
    u_host.key(2'h3);
    foreach (c[i]) begin
      u_host.wr(CLT_OFS_INPUT_LIMIT, {1'b1, i[0], c[i]});
      @(posedge i_mclk);
      #1;
      chk("restart", i[0], ctl.restart_100mv);
      chk("off", i == 5, ctl.limit_disable);
      if (i < 5) begin
        chk("target", ma[i], ctl.limit_target_ma);
        chk("trip", ma[i] * 95 / 100, ctl.limit_trip_ma);
      end
      rdchk(CLT_OFS_INPUT_LIMIT, {1'b0, i[0], c[i]});
    end
  endtask : t_ilim
  // Every code of each topoff and thermal field
  task automatic t_fields;
    for (int i = 0; i < 8; i++) begin
      logic [2:0] b;
      b = 3'(i);
      u_host.wr(CLT_OFS_TOPOFF, {b, b[0], b[1:0], b[2:1]});
      u_host.wr(CLT_OFS_THERMAL, {b[1:0], 2'b11, b[2], 2'b11, b[0]});
      @(posedge i_mclk);
      #1;
      chk("timer", 10 * i, ctl.topoff_minutes);
      chk("scale", b[0], ctl.test_scale_2p8a);
      chk("thr", 50 * (i % 4 + 1), ctl.topoff_current_ma);
      chk("volt", b[2:1], ctl.term_voltage);
      chk("die", b[1:0], ctl.die_temp);
      chk("thm", b[2], ctl.thermistor_monitor_off);
      chk("region", b[0], ctl.safety_region2);
      rdchk(CLT_OFS_THERMAL, {b[1:0], 2'b00, b[2], 2'b00, b[0]});
      rdchk(CLT_OFS_TOPOFF, {b, b[0], b[1:0], b[2:1]});
    end
  endtask : t_fields
  task automatic t_relock;
    u_host.key(2'h2);
    // Lock flag is registered one edge after the key lands
    @(posedge i_mclk);
    #1;
    chk("unlocked", 0, unlocked);
    u_host.wr(CLT_OFS_INPUT_LIMIT, 8'h05);
    rdchk(CLT_OFS_INPUT_LIMIT, 8'h7F);
  endtask : t_relock
  // Power-good rise, then standby loss, each restores defaults
  task automatic t_supply;
    u_host.key(2'h3);
    @(posedge i_mclk);
    #1;
    chk("unlocked", 1, unlocked);
    pgood = 1'b1;
    repeat (8) @(posedge i_mclk);
    rdchk(CLT_OFS_TOPOFF, 8'h60);
    rdchk(CLT_OFS_PROTECT, 8'h00);
    u_host.key(2'h3);
    u_host.wr(CLT_OFS_THERMAL, 8'hC1);
    rdchk(CLT_OFS_THERMAL, 8'hC1);
    // Leave the topoff away from default so the loss is visible
    u_host.wr(CLT_OFS_TOPOFF, 8'h00);
    stby_ok = 1'b0;
    repeat (8) @(posedge i_mclk);
    #1;
    stby_ok = 1'b1;
    repeat (8) @(posedge i_mclk);
    rdchk(CLT_OFS_THERMAL, 8'h08);
    rdchk(CLT_OFS_TOPOFF, 8'h60);
  endtask : t_supply
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end
  // Hang guard; whole run needs under two hundred cycles
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      final_report();
    end
  end
  initial begin
    i_nrst = 1'b0;
    stby_ok = 1'b1;
    pgood = 1'b0;
    repeat (5) @(posedge i_mclk);
    #1;
    i_nrst = 1'b1;
    repeat (6) @(posedge i_mclk);
    t_defaults();
    t_locked();
    t_ilim();
    t_fields();
    t_relock();
    t_supply();
    final_report();
  end
endmodule : testbench
